// file: rtl/sls_pkg.sv
package sls_pkg;
    // ==========================================
    // Operand word slots, fetch order
    localparam logic [2:0]  IDX_SRC      = 3'h0;
    localparam logic [2:0]  IDX_OFF      = 3'h1;
    localparam logic [2:0]  IDX_DX       = 3'h2;
    localparam logic [2:0]  IDX_DY       = 3'h3;
    localparam logic [2:0]  IDX_MAX      = 3'h4;
    localparam logic [2:0]  IDX_MIN      = 3'h5;
    localparam int          SLOT_COUNT   = 6;
    localparam logic [2:0]  WORDS_TO_BCD = 3'h4;
    localparam logic [2:0]  WORDS_TO_BIN = 3'h6;

    // ==========================================
    // Limits and reset values
    localparam logic [13:0] MAG_LIMIT    = 14'h270f;
    localparam logic [15:0] WORD_RST     = 16'h0000;
    localparam logic [2:0]  CNT_RST      = 3'h0;

    // ==========================================
    // Types
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_FETCH = 2'h1,
        ST_CALC  = 2'h3,
        ST_DONE  = 2'h2
    } sls_state_t;

    typedef enum logic {
        OP_TO_BCD = 1'h0,
        OP_TO_BIN = 1'h1
    } sls_op_t;

    typedef struct packed {
        logic fault;
        logic equal;
        logic carry;
        logic negative;
    } sls_flags_t;

    localparam sls_flags_t FLAGS_RST = '0;
endpackage

// file: rtl/sls_core.sv
`timescale 1ns/10ps
// Notes on behaviour
// - To-BCD op reads signed binary source, writes BCD magnitude, sign into carry
// - To-BCD op reads offset, horizontal span, vertical span at base+0..2
// - To-BCD result is vertical span over horizontal span times source minus offset
// - Both ops round the quotient to nearest integer before clamping and storing
// - To-BCD result saturates to plus or minus 9999
// - To-BCD faults on zero horizontal span or non-BCD vertical span
// - Equals flag set when stored result is zero, cleared when it is nonzero, kept on a fault
// - To-BCD carry set for negative result, cleared for zero or positive
// - Offset and slope may be positive, zero or negative
// - To-binary source is BCD magnitude with sign from carry flag
// - To-binary result is vertical over horizontal span times signed source plus offset
// - To-binary reads five parameters: offset, spans, maximum, minimum
// - To-binary result clamped between minimum and maximum limit words
// - To-binary faults on non-BCD source or horizontal span outside 0001..9999
// - To-binary writes signed binary, negative flag follows its top bit
// - Runs on each scan that finds it idle with condition true, or once per rising edge seen while idle
module sls_core
    import sls_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              scanTick,
    input  wire logic              execCond,
    input  wire logic              edgeMode,
    input  wire sls_op_t           opSel,
    input  wire logic [ADDR_W-1:0] srcAddr,
    input  wire logic [ADDR_W-1:0] parameterBase,
    input  wire logic [ADDR_W-1:0] resultAddr,
    input  wire logic              setCarryOp,
    input  wire logic              clearCarryOp,
    output logic [ADDR_W-1:0]      memAddr,
    output logic                   memRdEn,
    input  wire logic [15:0]       memRdData,
    output logic                   memWrEn,
    output logic [15:0]            memWrData,
    output sls_flags_t             flags,
    output logic                   busy,
    output logic                   done
);

    // ==========================================
    // Helpers
    function automatic logic isBcd(input logic [15:0] w);
        isBcd = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (w[4*i +: 4] > 4'h9) begin
                isBcd = 1'b0;
            end
        end
    endfunction

    function automatic logic [13:0] bcdToBin(input logic [15:0] w);
        bcdToBin = 14'(w[15:12] * 14'h3e8 + w[11:8] * 14'h64 + w[7:4] * 14'ha + 14'(w[3:0]));
    endfunction

    function automatic logic [15:0] binToBcd(input logic [13:0] v);
        binToBcd = {4'(v / 14'h3e8), 4'((v / 14'h64) % 14'ha), 4'((v / 14'ha) % 14'ha), 4'(v % 14'ha)};
    endfunction

    // ==========================================
    // State
    sls_state_t        state_q,     state_d;
    sls_op_t           op_q,        op_d;
    logic [ADDR_W-1:0] srcAddr_q,   srcAddr_d;
    logic [ADDR_W-1:0] base_q,      base_d;
    logic [ADDR_W-1:0] resAddr_q,   resAddr_d;
    logic [ADDR_W-1:0] memAddr_q,   memAddr_d;
    logic              memRdEn_q,   memRdEn_d;
    logic              memWrEn_q,   memWrEn_d;
    logic [15:0]       memWrData_q, memWrData_d;
    logic [2:0]        rdCnt_q,     rdCnt_d;
    logic [2:0]        rdIdx_q,     rdIdx_d;
    logic [2:0]        capIdx_q,    capIdx_d;
    logic              capEn_q,     capEn_d;
    logic              condPrev_q,  condPrev_d;
    sls_flags_t        flags_q,     flags_d;
    logic [15:0]       word_q [SLOT_COUNT];
    logic [15:0]       word_d [SLOT_COUNT];
    logic [2:0]        nWords;
    logic              start;

    // ==========================================
    // Arithmetic
    logic [13:0]        srcBin, dxBin, dyBin, magClamp;
    logic signed [16:0] diffS, denS;
    logic signed [33:0] numS;
    logic [33:0]        numMag;
    logic [15:0]        denMag;
    logic [35:0]        qMag;
    logic signed [36:0] qS;
    logic [15:0]        calcRes;
    logic               calcErr, calcNeg;

    always_comb begin
        srcBin = bcdToBin(word_q[IDX_SRC]);
        dxBin  = bcdToBin(word_q[IDX_DX]);
        dyBin  = bcdToBin(word_q[IDX_DY]);
        if (op_q == OP_TO_BCD) begin
            calcErr = (word_q[IDX_DX] == WORD_RST) || !isBcd(word_q[IDX_DY]);
            diffS   = $signed({word_q[IDX_SRC][15], word_q[IDX_SRC]})
                    - $signed({word_q[IDX_OFF][15], word_q[IDX_OFF]});
            numS    = 34'($signed({1'b0, dyBin})) * 34'(diffS);
            denS    = $signed({word_q[IDX_DX][15], word_q[IDX_DX]});
        end else begin
            calcErr = !isBcd(word_q[IDX_SRC]) || !isBcd(word_q[IDX_DX])
                    || (word_q[IDX_DX] == WORD_RST);
            diffS   = (flags_q.carry ? -$signed({3'h0, srcBin}) : $signed({3'h0, srcBin}))
                    + $signed({word_q[IDX_OFF][15], word_q[IDX_OFF]});
            numS    = 34'($signed(word_q[IDX_DY])) * 34'(diffS);
            denS    = $signed({3'h0, dxBin});
        end
        numMag = numS[33] ? 34'(-numS) : 34'(numS);
        denMag = denS[16] ? 16'(-denS) : 16'(denS);
        if (denMag == WORD_RST) begin
            denMag = 16'h0001;
        end
        qMag     = ({1'b0, numMag, 1'b0} + 36'(denMag)) / {19'h0, denMag, 1'b0};
        calcNeg  = (numS[33] ^ denS[16]) && (qMag != 36'h0);
        magClamp = (qMag > 36'(MAG_LIMIT)) ? MAG_LIMIT : qMag[13:0];
        qS       = calcNeg ? -$signed({1'b0, qMag}) : $signed({1'b0, qMag});
        if (op_q == OP_TO_BCD) begin
            calcRes = binToBcd(magClamp);
        end else if (qS < $signed(word_q[IDX_MIN])) begin
            calcRes = word_q[IDX_MIN];
        end else if (qS > $signed(word_q[IDX_MAX])) begin
            calcRes = word_q[IDX_MAX];
        end else begin
            calcRes = qS[15:0];
        end
    end

    // ==========================================
    // Sequencing
    assign nWords = (op_q == OP_TO_BCD) ? WORDS_TO_BCD : WORDS_TO_BIN;
    assign start  = (state_q == ST_IDLE) && scanTick && execCond
                  && (!edgeMode || !condPrev_q);

    always_comb begin
        state_d     = state_q;
        op_d        = op_q;
        srcAddr_d   = srcAddr_q;
        base_d      = base_q;
        resAddr_d   = resAddr_q;
        memAddr_d   = memAddr_q;
        memRdEn_d   = 1'b0;
        memWrEn_d   = 1'b0;
        memWrData_d = memWrData_q;
        rdCnt_d     = rdCnt_q;
        rdIdx_d     = rdIdx_q;
        capEn_d     = memRdEn_q;
        capIdx_d    = rdIdx_q;
        condPrev_d  = scanTick ? execCond : condPrev_q;
        flags_d     = flags_q;
        word_d      = word_q;
        if (capEn_q) begin
            word_d[capIdx_q] = memRdData;
        end
        if (setCarryOp) begin
            flags_d.carry = 1'b1;
        end else if (clearCarryOp) begin
            flags_d.carry = 1'b0;
        end
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    op_d      = opSel;
                    srcAddr_d = srcAddr;
                    base_d    = parameterBase;
                    resAddr_d = resultAddr;
                    rdCnt_d   = CNT_RST;
                    state_d   = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (rdCnt_q < nWords) begin
                    memRdEn_d = 1'b1;
                    memAddr_d = (rdCnt_q == IDX_SRC) ? srcAddr_q : base_q + ADDR_W'(rdCnt_q - 3'h1);
                    rdIdx_d   = rdCnt_q;
                    rdCnt_d   = rdCnt_q + 3'h1;
                end
                if (capEn_q && (capIdx_q == nWords - 3'h1)) begin
                    state_d = ST_CALC;
                end
            end
            ST_CALC: begin
                flags_d.fault = calcErr;
                if (!calcErr) begin
                    memWrEn_d     = 1'b1;
                    memAddr_d     = resAddr_q;
                    memWrData_d   = calcRes;
                    flags_d.equal = (calcRes == WORD_RST);
                    if (op_q == OP_TO_BCD) begin
                        flags_d.carry = calcNeg;
                    end else begin
                        flags_d.negative = calcRes[15];
                    end
                end
                state_d = ST_DONE;
            end
            ST_DONE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= ST_IDLE;
            op_q        <= OP_TO_BCD;
            srcAddr_q   <= '0;
            base_q      <= '0;
            resAddr_q   <= '0;
            memAddr_q   <= '0;
            memRdEn_q   <= 1'b0;
            memWrEn_q   <= 1'b0;
            memWrData_q <= WORD_RST;
            rdCnt_q     <= CNT_RST;
            rdIdx_q     <= CNT_RST;
            capIdx_q    <= CNT_RST;
            capEn_q     <= 1'b0;
            condPrev_q  <= 1'b0;
            flags_q     <= FLAGS_RST;
            for (int i = 0; i < SLOT_COUNT; i++) begin
                word_q[i] <= WORD_RST;
            end
        end else begin
            state_q     <= state_d;
            op_q        <= op_d;
            srcAddr_q   <= srcAddr_d;
            base_q      <= base_d;
            resAddr_q   <= resAddr_d;
            memAddr_q   <= memAddr_d;
            memRdEn_q   <= memRdEn_d;
            memWrEn_q   <= memWrEn_d;
            memWrData_q <= memWrData_d;
            rdCnt_q     <= rdCnt_d;
            rdIdx_q     <= rdIdx_d;
            capIdx_q    <= capIdx_d;
            capEn_q     <= capEn_d;
            condPrev_q  <= condPrev_d;
            flags_q     <= flags_d;
            word_q      <= word_d;
        end
    end

    assign memAddr   = memAddr_q;
    assign memRdEn   = memRdEn_q;
    assign memWrEn   = memWrEn_q;
    assign memWrData = memWrData_q;
    assign flags     = flags_q;
    assign busy      = (state_q != ST_IDLE);
    assign done      = (state_q == ST_DONE);

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_fault_no_write;
        done && flags_q.fault |-> !$past(memWrEn_d) && !memWrEn_q;
    endproperty
    a_fault_no_write: assert property (p_fault_no_write) else $error("write despite fault");

    property p_bcd_range;
        memWrEn_q && op_q == OP_TO_BCD |-> isBcd(memWrData_q) && memWrData_q <= 16'h9999;
    endproperty
    a_bcd_range: assert property (p_bcd_range) else $error("bcd result out of range");

    property p_carry_zero;
        memWrEn_q && op_q == OP_TO_BCD && memWrData_q == WORD_RST |-> !flags_q.carry;
    endproperty
    a_carry_zero: assert property (p_carry_zero) else $error("carry set on zero");

    property p_equal;
        memWrEn_q |-> flags_q.equal == (memWrData_q == WORD_RST);
    endproperty
    a_equal: assert property (p_equal) else $error("equals flag wrong");

    property p_negative;
        memWrEn_q && op_q == OP_TO_BIN |-> flags_q.negative == memWrData_q[15];
    endproperty
    a_negative: assert property (p_negative) else $error("negative flag wrong");

    property p_bin_clamp;
        memWrEn_q && op_q == OP_TO_BIN && $signed(word_q[IDX_MIN]) <= $signed(word_q[IDX_MAX])
            |-> $signed(memWrData_q) >= $signed(word_q[IDX_MIN])
             && $signed(memWrData_q) <= $signed(word_q[IDX_MAX]);
    endproperty
    a_bin_clamp: assert property (p_bin_clamp) else $error("binary result outside limits");

    property p_run_time;
        start |=> busy ##[7:9] done;
    endproperty
    a_run_time: assert property (p_run_time) else $error("operation did not finish in time");

    property p_span_fault;
        done && op_q == OP_TO_BCD && word_q[IDX_DX] == WORD_RST |-> flags_q.fault;
    endproperty
    a_span_fault: assert property (p_span_fault) else $error("zero span not flagged");

    property p_src_fault;
        done && op_q == OP_TO_BIN && !isBcd(word_q[IDX_SRC]) |-> flags_q.fault;
    endproperty
    a_src_fault: assert property (p_src_fault) else $error("bad source not flagged");

    c_neg_bcd: cover property (memWrEn_q && op_q == OP_TO_BCD && flags_q.carry);
    c_bin_write: cover property (memWrEn_q && op_q == OP_TO_BIN);
    c_fault: cover property (done && flags_q.fault);
endmodule

// file: sim/sls_core_tb.sv
`timescale 1ns/10ps
module sls_core_tb
    import sls_pkg::*;
;
    // ==========================================
    // Case table
    typedef struct packed {
        logic        op;
        logic        cin;
        logic [15:0] src, off, dx, dy, mx, mn;
        logic        wr;
        logic [15:0] res;
        logic [3:0]  flg, msk;
    } sls_row_t;

    // Fields: op cin src off dx dy max min write result flags mask
    sls_row_t rows [17] = '{
        '{1'h0,1'h0,16'h0064,16'h0000,16'h0004,16'h0003,16'h0000,16'h0000,1'h1,16'h0075,4'h0,4'he},
        '{1'h0,1'h0,16'h0001,16'h0000,16'h0000,16'h0001,16'h0000,16'h0000,1'h0,16'h0000,4'h8,4'h8},
        '{1'h0,1'h0,16'h0000,16'h000a,16'h0004,16'h0003,16'h0000,16'h0000,1'h1,16'h0008,4'h2,4'he},
        '{1'h0,1'h0,16'h0001,16'h0000,16'h0001,16'h000a,16'h0000,16'h0000,1'h0,16'h0000,4'h8,4'h8},
        '{1'h0,1'h0,16'h7fff,16'h0000,16'h0001,16'h0002,16'h0000,16'h0000,1'h1,16'h9999,4'h0,4'he},
        '{1'h0,1'h0,16'h8000,16'h0000,16'h0001,16'h0001,16'h0000,16'h0000,1'h1,16'h9999,4'h2,4'he},
        '{1'h0,1'h0,16'h0008,16'h0000,16'hfffe,16'h0005,16'h0000,16'h0000,1'h1,16'h0020,4'h2,4'he},
        '{1'h0,1'h0,16'h0000,16'h0001,16'h0004,16'h0001,16'h0000,16'h0000,1'h1,16'h0000,4'h4,4'he},
        '{1'h1,1'h1,16'h0003,16'h0000,16'h0002,16'h0001,16'h7fff,16'h8000,1'h1,16'hfffe,4'h3,4'hf},
        '{1'h1,1'h0,16'h00a0,16'h0000,16'h0001,16'h0001,16'h7fff,16'h8000,1'h0,16'h0000,4'h8,4'h8},
        '{1'h1,1'h0,16'h0005,16'hfffb,16'h0001,16'h0009,16'h7fff,16'h8000,1'h1,16'h0000,4'h4,4'hf},
        '{1'h1,1'h0,16'h0001,16'h0000,16'h0000,16'h0001,16'h7fff,16'h8000,1'h0,16'h0000,4'h8,4'h8},
        '{1'h1,1'h0,16'h0100,16'h0000,16'h0001,16'h0001,16'h0032,16'hffce,1'h1,16'h0032,4'h0,4'hf},
        '{1'h1,1'h0,16'h0001,16'h0000,16'h001f,16'h0001,16'h7fff,16'h8000,1'h0,16'h0000,4'h8,4'h8},
        '{1'h1,1'h1,16'h0100,16'h0000,16'h0001,16'h0001,16'h0032,16'hffce,1'h1,16'hffce,4'h3,4'hf},
        '{1'h1,1'h0,16'h0004,16'h0001,16'h0001,16'hffff,16'h7fff,16'h8000,1'h1,16'hfffb,4'h1,4'hf},
        '{1'h1,1'h0,16'h9999,16'h0000,16'h9999,16'h0007,16'h7fff,16'h8000,1'h1,16'h0007,4'h0,4'hf}
    };

    logic        clk_sys;
    logic        rst_n;
    logic        scanTick;
    logic        execCond;
    logic        edgeMode;
    sls_op_t     opSel;
    logic [15:0] srcAddr;
    logic [15:0] parameterBase;
    logic [15:0] resultAddr;
    logic        setCarryOp;
    logic        clearCarryOp;
    logic [15:0] memAddr;
    logic        memRdEn;
    logic [15:0] memRdData;
    logic        memWrEn;
    logic [15:0] memWrData;
    sls_flags_t  flags;
    logic        busy;
    logic        done;
    logic [15:0] memModel [0:255];
    int          checksDone;
    int          failures;

    always #4 clk_sys = ~clk_sys;

    // ==========================================
    // Data memory, one cycle read latency
    always @(posedge clk_sys) begin
        if (memRdEn) begin
            memRdData <= memModel[memAddr[7:0]];
        end else begin
            memRdData <= ~memRdData;
        end
        if (memWrEn) begin
            memModel[memAddr[7:0]] <= memWrData;
        end
    end

    sls_core DUT (
        .clk_sys       (clk_sys),
        .rst_n         (rst_n),
        .scanTick      (scanTick),
        .execCond      (execCond),
        .edgeMode      (edgeMode),
        .opSel         (opSel),
        .srcAddr       (srcAddr),
        .parameterBase (parameterBase),
        .resultAddr    (resultAddr),
        .setCarryOp    (setCarryOp),
        .clearCarryOp  (clearCarryOp),
        .memAddr       (memAddr),
        .memRdEn       (memRdEn),
        .memRdData     (memRdData),
        .memWrEn       (memWrEn),
        .memWrData     (memWrData),
        .flags         (flags),
        .busy          (busy),
        .done          (done)
    );

    // ==========================================
    // Tasks
    task automatic complete_run();
        $display("checksDone=%0d failures=%0d", checksDone, failures);
        if (failures == 0 && checksDone > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checksDone++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic pulse_tick(input logic cond);
        @(posedge clk_sys);
        #1;
        execCond = cond;
        scanTick = 1'b1;
        @(posedge clk_sys);
        #1;
        scanTick = 1'b0;
    endtask

    task automatic no_start();
        logic seen;
        seen = 1'b0;
        repeat (12) begin
            @(posedge clk_sys);
            #1;
            seen = seen | busy | done;
        end
        chk(16'(seen), 16'h0000, "unexpected start");
    endtask

    task automatic wait_done(input int lat);
        int n;
        n = 0;
        while (done !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 20) begin
            failures++;
            $display("mismatch at %0t: no done", $time);
            complete_run();
        end else begin
            chk(16'(n), 16'(lat), "latency");
        end
    endtask

    task automatic set_carry(input logic val);
        @(posedge clk_sys);
        #1;
        setCarryOp = val;
        clearCarryOp = ~val;
        @(posedge clk_sys);
        #1;
        setCarryOp = 1'b0;
        clearCarryOp = 1'b0;
    endtask

    task automatic run_row(input sls_row_t r);
        memModel[8'h10] = r.src;
        memModel[8'h20] = r.off;
        memModel[8'h21] = r.dx;
        memModel[8'h22] = r.dy;
        memModel[8'h23] = r.mx;
        memModel[8'h24] = r.mn;
        memModel[8'h30] = 16'h5a5a;
        opSel = sls_op_t'(r.op);
        if (r.op) begin
            set_carry(r.cin);
        end
        pulse_tick(1'b1);
        wait_done(r.op ? 9 : 7);
        chk(16'(memWrEn), 16'(r.wr), "write strobe");
        if (r.wr) begin
            chk(memAddr, 16'h0030, "write address");
            chk(memWrData, r.res, "result");
        end
        chk(16'(flags & r.msk), 16'(r.flg & r.msk), "flags");
        @(posedge clk_sys);
        #1;
        chk(memModel[8'h30], r.wr ? r.res : 16'h5a5a, "stored word");
        chk(16'(busy), 16'h0000, "busy after done");
    endtask

    // ==========================================
    // Main sequence
    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        scanTick = 1'b0;
        execCond = 1'b0;
        edgeMode = 1'b0;
        opSel = OP_TO_BCD;
        srcAddr = 16'h0010;
        parameterBase = 16'h0020;
        resultAddr = 16'h0030;
        setCarryOp = 1'b0;
        clearCarryOp = 1'b0;
        checksDone = 0;
        failures = 0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk(16'({flags, busy, done, memWrEn, memRdEn}), 16'h0000, "reset outputs");
        rst_n = 1'b1;
        @(posedge clk_sys);
        #1;
        setCarryOp = 1'b1;
        clearCarryOp = 1'b1;
        @(posedge clk_sys);
        #1;
        setCarryOp = 1'b0;
        clearCarryOp = 1'b0;
        chk(16'(flags.carry), 16'h0001, "carry set");
        set_carry(1'b0);
        chk(16'(flags.carry), 16'h0000, "carry clear");
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        // Condition off, then tick while busy
        pulse_tick(1'b0);
        no_start();
        opSel = OP_TO_BCD;
        pulse_tick(1'b1);
        pulse_tick(1'b1);
        wait_done(5);
        no_start();
        // Rising edge form
        edgeMode = 1'b1;
        pulse_tick(1'b1);
        no_start();
        pulse_tick(1'b0);
        no_start();
        pulse_tick(1'b1);
        wait_done(7);
        // Reset in mid-run, then recovery
        edgeMode = 1'b0;
        pulse_tick(1'b1);
        repeat (3) begin
            @(posedge clk_sys);
            #1;
        end
        rst_n = 1'b0;
        #1;
        chk(16'({flags, busy, done, memWrEn, memRdEn}), 16'h0000, "mid-run reset");
        @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        pulse_tick(1'b1);
        wait_done(7);
        complete_run();
    end
endmodule
